/* rtl/bmwd_pkg.sv */
`default_nettype none
package bmwd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // address and field layout
  localparam int unsigned HOST_ADDR_W   = 32;
  localparam int unsigned PADDR_W       = 8;
  localparam int unsigned PDATA_W       = 32;
  localparam int unsigned REG_W         = 16;
  localparam int unsigned FIELD_MSB     = 15;
  localparam int unsigned FIELD_LSB     = 4;
  localparam int unsigned FIELD_W       = FIELD_MSB - FIELD_LSB + 1;
  localparam int unsigned LOW_ADDR_W    = HOST_ADDR_W - FIELD_W;
  localparam int unsigned NUM_WIN_REGS  = 4;
  localparam int unsigned CNT_W         = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [PADDR_W-1:0] NP_BASE_IDX   = 8'h20;
  localparam logic [PADDR_W-1:0] NP_LIMIT_IDX  = 8'h22;
  localparam logic [PADDR_W-1:0] PF_BASE_IDX   = 8'h24;
  localparam logic [PADDR_W-1:0] PF_LIMIT_IDX  = 8'h26;
  localparam logic [PADDR_W-1:0] STATUS_IDX    = 8'h28;
  localparam logic [PADDR_W-1:0] NP_COUNT_IDX  = 8'h29;
  localparam logic [PADDR_W-1:0] PF_COUNT_IDX  = 8'h2a;
  localparam logic [PADDR_W-1:0] MISS_COUNT_IDX = 8'h2b;
  localparam int unsigned        IDX_SHIFT     = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // window register slots and reset values
  localparam int unsigned SLOT_NP_BASE  = 0;
  localparam int unsigned SLOT_NP_LIMIT = 1;
  localparam int unsigned SLOT_PF_BASE  = 2;
  localparam int unsigned SLOT_PF_LIMIT = 3;
  localparam logic [REG_W-1:0] BASE_RESET  = 16'hfff0;
  localparam logic [REG_W-1:0] LIMIT_RESET = 16'h0000;
  localparam logic [LOW_ADDR_W-1:0] LOW_ZEROS = 20'h00000;
  localparam logic [LOW_ADDR_W-1:0] LOW_ONES  = 20'hfffff;

  ////////////////////////////////////////////////////////////////////////////////
  // status bit positions
  localparam int unsigned ST_LAST_VALID = 0;
  localparam int unsigned ST_LAST_SEC   = 1;
  localparam int unsigned ST_LAST_NP    = 2;
  localparam int unsigned ST_LAST_PF    = 3;
  localparam int unsigned ST_NP_OPEN    = 4;
  localparam int unsigned ST_PF_OPEN    = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // host request and routing answer
  typedef struct packed {
    logic                   valid;
    logic                   is_mem;
    logic [HOST_ADDR_W-1:0] addr;
  } bmwd_req_t;

  typedef struct packed {
    logic                   valid;
    logic                   to_secondary;
    logic                   np_hit;
    logic                   pf_hit;
    logic [HOST_ADDR_W-1:0] addr;
  } bmwd_route_t;

endpackage
`default_nettype wire

/* rtl/bmwd_window_match.sv */
`timescale 1ns/10ps
`default_nettype none

module bmwd_window_match #(
  parameter int unsigned ADDR_W  = bmwd_pkg::HOST_ADDR_W,
  parameter int unsigned FIELD_W = bmwd_pkg::FIELD_W
) (
  input  wire logic [FIELD_W-1:0] base_field_i,
  input  wire logic [FIELD_W-1:0] limit_field_i,
  input  wire logic [ADDR_W-1:0]  addr_i,
  output logic                    hit_o
);

  logic [ADDR_W-1:0] base_full;
  logic [ADDR_W-1:0] limit_full;

  assign base_full  = {base_field_i, bmwd_pkg::LOW_ZEROS};
  assign limit_full = {limit_field_i, bmwd_pkg::LOW_ONES};

  // inclusive compare; base above limit matches nothing
  assign hit_o = (addr_i >= base_full) && (addr_i <= limit_full);

endmodule

`default_nettype wire

/* rtl/bmwd_decode.sv */
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module bmwd_decode #(
  parameter int unsigned CNT_W = bmwd_pkg::CNT_W
) (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  // apb slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [bmwd_pkg::PADDR_W-1:0]  paddr_i,
  input  wire logic [bmwd_pkg::PDATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]                    pstrb_i,
  output logic                               pready_o,
  output logic [bmwd_pkg::PDATA_W-1:0]       prdata_o,
  output logic                               pslverr_o,
  // host memory access in, routing answer out
  input  wire bmwd_pkg::bmwd_req_t           host_req_i,
  output bmwd_pkg::bmwd_route_t              route_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [bmwd_pkg::FIELD_W-1:0]     win_reg [bmwd_pkg::NUM_WIN_REGS];
  logic                             pready_reg;
  logic [bmwd_pkg::PDATA_W-1:0]     prdata_reg;
  logic [bmwd_pkg::PDATA_W-1:0]     prdata_next;
  logic                             pslverr_reg;
  logic                             pslverr_next;
  bmwd_pkg::bmwd_route_t            route_reg;
  bmwd_pkg::bmwd_route_t            route_next;
  logic [CNT_W-1:0]                 np_count_reg;
  logic [CNT_W-1:0]                 pf_count_reg;
  logic [CNT_W-1:0]                 miss_count_reg;
  logic [bmwd_pkg::PADDR_W-1:0]     reg_idx;
  logic                             idx_aligned;
  logic                             apb_access;
  logic                             apb_commit;
  logic                             wr_commit;
  logic                             lo_lane_wr;
  logic                             hi_lane_wr;
  logic [bmwd_pkg::NUM_WIN_REGS-1:0] win_sel;
  logic                             np_hit;
  logic                             pf_hit;
  logic                             np_open;
  logic                             pf_open;
  logic [5:0]                       status_bits;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign reg_idx     = paddr_i >> bmwd_pkg::IDX_SHIFT;
  assign idx_aligned = (paddr_i[bmwd_pkg::IDX_SHIFT-1:0] == 2'h0);
  assign apb_access  = psel_i && penable_i && !pready_reg;
  assign apb_commit  = psel_i && penable_i && pready_reg;
  assign wr_commit   = apb_commit && pwrite_i;
  assign lo_lane_wr  = wr_commit && pstrb_i[0];
  assign hi_lane_wr  = wr_commit && pstrb_i[1];

  assign win_sel[bmwd_pkg::SLOT_NP_BASE]  = idx_aligned && (reg_idx == bmwd_pkg::NP_BASE_IDX);
  assign win_sel[bmwd_pkg::SLOT_NP_LIMIT] = idx_aligned && (reg_idx == bmwd_pkg::NP_LIMIT_IDX);
  assign win_sel[bmwd_pkg::SLOT_PF_BASE]  = idx_aligned && (reg_idx == bmwd_pkg::PF_BASE_IDX);
  assign win_sel[bmwd_pkg::SLOT_PF_LIMIT] = idx_aligned && (reg_idx == bmwd_pkg::PF_LIMIT_IDX);

  ////////////////////////////////////////////////////////////////////////////////
  // apb handshake, one wait state then pready for one cycle

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= apb_access;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (apb_access) begin
      prdata_reg  <= pwrite_i ? '0 : prdata_next;
      pslverr_reg <= pslverr_next;
    end else if (apb_commit) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // window registers

  for (genvar g = 0; g < bmwd_pkg::NUM_WIN_REGS; g++) begin : g_win
    localparam logic [bmwd_pkg::REG_W-1:0] RST_VAL =
      (g == bmwd_pkg::SLOT_NP_BASE || g == bmwd_pkg::SLOT_PF_BASE) ?
      bmwd_pkg::BASE_RESET : bmwd_pkg::LIMIT_RESET;

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        win_reg[g] <= RST_VAL[bmwd_pkg::FIELD_MSB:bmwd_pkg::FIELD_LSB];
      end else if (win_sel[g]) begin
        // low lane holds bits 7:4, bits 3:0 are not stored
        if (lo_lane_wr) begin
          win_reg[g][3:0] <= pwdata_i[7:bmwd_pkg::FIELD_LSB];
        end
        if (hi_lane_wr) begin
          win_reg[g][bmwd_pkg::FIELD_W-1:4] <= pwdata_i[bmwd_pkg::FIELD_MSB:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  assign status_bits = {pf_open, np_open, route_reg.pf_hit, route_reg.np_hit,
                        route_reg.to_secondary, route_reg.valid};

  always_comb begin
    prdata_next  = '0;
    pslverr_next = 1'b0;
    if (!idx_aligned) begin
      pslverr_next = 1'b1;
    end else begin
      case (reg_idx)
        bmwd_pkg::NP_BASE_IDX: begin
          prdata_next[bmwd_pkg::FIELD_MSB:0] =
            {win_reg[bmwd_pkg::SLOT_NP_BASE], 4'h0};
        end
        bmwd_pkg::NP_LIMIT_IDX: begin
          prdata_next[bmwd_pkg::FIELD_MSB:0] =
            {win_reg[bmwd_pkg::SLOT_NP_LIMIT], 4'h0};
        end
        bmwd_pkg::PF_BASE_IDX: begin
          prdata_next[bmwd_pkg::FIELD_MSB:0] =
            {win_reg[bmwd_pkg::SLOT_PF_BASE], 4'h0};
        end
        bmwd_pkg::PF_LIMIT_IDX: begin
          prdata_next[bmwd_pkg::FIELD_MSB:0] =
            {win_reg[bmwd_pkg::SLOT_PF_LIMIT], 4'h0};
        end
        bmwd_pkg::STATUS_IDX: begin
          prdata_next[bmwd_pkg::ST_PF_OPEN:bmwd_pkg::ST_LAST_VALID] = status_bits;
        end
        bmwd_pkg::NP_COUNT_IDX: begin
          prdata_next[CNT_W-1:0] = np_count_reg;
        end
        bmwd_pkg::PF_COUNT_IDX: begin
          prdata_next[CNT_W-1:0] = pf_count_reg;
        end
        bmwd_pkg::MISS_COUNT_IDX: begin
          prdata_next[CNT_W-1:0] = miss_count_reg;
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // window decode

  bmwd_window_match u_np_match (
    .base_field_i  (win_reg[bmwd_pkg::SLOT_NP_BASE]),
    .limit_field_i (win_reg[bmwd_pkg::SLOT_NP_LIMIT]),
    .addr_i        (host_req_i.addr),
    .hit_o         (np_hit)
  );

  bmwd_window_match u_pf_match (
    .base_field_i  (win_reg[bmwd_pkg::SLOT_PF_BASE]),
    .limit_field_i (win_reg[bmwd_pkg::SLOT_PF_LIMIT]),
    .addr_i        (host_req_i.addr),
    .hit_o         (pf_hit)
  );

  assign np_open = (win_reg[bmwd_pkg::SLOT_NP_BASE] <= win_reg[bmwd_pkg::SLOT_NP_LIMIT]);
  assign pf_open = (win_reg[bmwd_pkg::SLOT_PF_BASE] <= win_reg[bmwd_pkg::SLOT_PF_LIMIT]);

  always_comb begin
    route_next              = '0;
    route_next.valid        = host_req_i.valid;
    route_next.addr         = host_req_i.addr;
    if (host_req_i.valid && host_req_i.is_mem) begin
      route_next.np_hit       = np_hit;
      route_next.pf_hit       = pf_hit;
      route_next.to_secondary = np_hit || pf_hit;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      route_reg <= '0;
    end else begin
      route_reg <= route_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // routing counters

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      np_count_reg <= '0;
    end else if (route_next.np_hit) begin
      np_count_reg <= np_count_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pf_count_reg <= '0;
    end else if (route_next.pf_hit) begin
      pf_count_reg <= pf_count_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      miss_count_reg <= '0;
    end else if (host_req_i.valid && host_req_i.is_mem && !route_next.to_secondary) begin
      miss_count_reg <= miss_count_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready_o  = pready_reg;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg;
  assign route_o   = route_reg;

endmodule

`default_nettype wire

/* sim/bmwd_decode_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module bmwd_decode_checker #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic                  mclk_i,
  input wire logic                  rst_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [7:0]            paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic [3:0]            pstrb_i,
  input wire logic                  pready_o,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pslverr_o,
  input wire bmwd_pkg::bmwd_req_t   host_req_i,
  input wire bmwd_pkg::bmwd_route_t route_o
);
  logic win;
  assign win = paddr_i[1:0] == 2'b00 && (paddr_i >> 2) inside {bmwd_pkg::NP_BASE_IDX,
    bmwd_pkg::NP_LIMIT_IDX, bmwd_pkg::PF_BASE_IDX, bmwd_pkg::PF_LIMIT_IDX};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  a_ready_second_access: assert property (s_setup ##1 s_access |=> pready_o)
    else $error("ready not in second access cycle");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_ready_needs_access: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("ready without access phase");
  a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_rsvd_bits_zero: assert property (pready_o && !pwrite_i && win
    |-> prdata_o[3:0] == 4'h0 && prdata_o[31:16] == 16'h0) else $error("reserved bits set");
  a_window_no_error: assert property (pready_o |-> (pslverr_o == !win) ||
    (paddr_i >> 2) > bmwd_pkg::PF_LIMIT_IDX) else $error("error flag wrong");
  a_route_one_cycle: assert property (host_req_i.valid
    |=> route_o.valid && route_o.addr == $past(host_req_i.addr)) else $error("route late");
  a_route_idle: assert property (!host_req_i.valid |=> !route_o.valid)
    else $error("route without request");
  a_nonmem_no_hit: assert property (host_req_i.valid && !host_req_i.is_mem
    |=> !route_o.to_secondary && !route_o.np_hit && !route_o.pf_hit) else $error("io hit");
  a_sec_from_hits: assert property (route_o.valid
    |-> route_o.to_secondary == (route_o.np_hit || route_o.pf_hit)) else $error("bad route");
endmodule
bind bmwd_decode bmwd_decode_checker #(.CNT_W(CNT_W)) u_bmwd_decode_checker (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .host_req_i(host_req_i), .route_o(route_o));
`default_nettype wire

/* sim/bmwd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module bmwd_host_model (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic          go_i,
  input  wire logic          is_mem_i,
  input  wire logic [31:0]   addr_i,
  output bmwd_pkg::bmwd_req_t req_o
);
  logic [31:0] last_reg;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      last_reg <= 32'h0;
    end else if (go_i) begin
      last_reg <= addr_i;
    end
  end
  // idle bus shows the inverse of the last address
  assign req_o.valid = go_i;
  assign req_o.is_mem = go_i & is_mem_i;
  assign req_o.addr = go_i ? addr_i : ~last_reg;
endmodule
`default_nettype wire

/* sim/bridge_memory_window_decode_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module bridge_memory_window_decode_bench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic h_go = 1'b0;
  logic h_mem = 1'b0;
  logic [31:0] h_addr = 32'h0;
  logic pready, pslverr, err, pend = 1'b0;
  logic [31:0] prdata, rd, b, l, d, seed = 32'h1b86;
  logic [15:0] m [4];
  logic [7:0] ra [4];
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_np = 0;
  int n_pf = 0;
  int n_miss = 0;
  bmwd_pkg::bmwd_req_t host_req;
  bmwd_pkg::bmwd_route_t route, pexp, cur;
  always #50 mclk_i = ~mclk_i;
  bmwd_decode u_bmwd_decode (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .host_req_i(host_req), .route_o(route));
  bmwd_host_model u_bmwd_host_model (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(h_go),
    .is_mem_i(h_mem), .addr_i(h_addr), .req_o(host_req));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic bmwd_pkg::bmwd_route_t model(input bmwd_pkg::bmwd_req_t q);
    bmwd_pkg::bmwd_route_t r;
    r = '0;
    r.valid = q.valid;
    r.addr = q.addr;
    r.np_hit = q.is_mem && q.addr >= {m[0][15:4], 20'h0}
      && q.addr <= {m[1][15:4], 20'hfffff};
    r.pf_hit = q.is_mem && q.addr >= {m[2][15:4], 20'h0}
      && q.addr <= {m[3][15:4], 20'hfffff};
    r.to_secondary = r.np_hit || r.pf_hit;
    return r;
  endfunction
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_route(input bmwd_pkg::bmwd_route_t got, input bmwd_pkg::bmwd_route_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                     input logic [3:0] s);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    pstrb <= s;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_reg(input int i, input logic [31:0] dt, input logic [3:0] s);
    logic [15:0] k;
    k = {{8{s[1]}}, {8{s[0]}}} & 16'hfff0;
    apb(1'b1, ra[i], dt, s);
    chk_rd({31'h0, err}, 32'h0);
    m[i] = (m[i] & ~k) | (dt[15:0] & k);
  endtask
  task automatic rd_reg(input int i);
    apb(1'b0, ra[i], 32'h0, 4'h0);
    chk_rd(rd, {16'h0, m[i]});
  endtask
  task automatic rd_own(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk_rd({31'h0, err}, 32'h0);
    chk_rd(rd, e);
  endtask
  task automatic host(input logic mm, input logic [31:0] a);
    h_go <= 1'b1;
    h_mem <= mm;
    h_addr <= a;
    @(posedge mclk_i);
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (pend) chk_route(route, pexp);
    pend <= host_req.valid === 1'b1 && !rst_i;
    cur = model(host_req);
    pexp <= cur;
    if (!rst_i && cur.valid === 1'b1 && host_req.is_mem === 1'b1) begin
      if (cur.np_hit) n_np++;
      if (cur.pf_hit) n_pf++;
      if (!cur.to_secondary) n_miss++;
    end
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    ra = '{bmwd_pkg::NP_BASE_IDX << 2, bmwd_pkg::NP_LIMIT_IDX << 2,
           bmwd_pkg::PF_BASE_IDX << 2, bmwd_pkg::PF_LIMIT_IDX << 2};
    m = '{16'hfff0, 16'h0000, 16'hfff0, 16'h0000};
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd_reg(i);
    host(1'b1, 32'h0);
    host(1'b1, 32'hffff_ffff);
    h_go <= 1'b0;
    foreach (ra[i]) begin
      apb(i[0], ra[i] + 8'h1 + 8'h3 * i[1], 32'hffff_ffff, 4'hf);
      chk_rd({31'h0, err}, 32'h1);
    end
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      wr_reg(3, seed, 4'h1 << s);
      rd_reg(3);
    end
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        d = seed;
        if (k % 2 == 0 && i % 2 == 1) d[15:4] = m[i - 1][15:4] + 12'(seed[19:17]);
        if (k % 4 == 0 && i == 2) d[15:4] = m[0][15:4];
        wr_reg(i, d, 4'hf);
        rd_reg(i);
      end
      for (int w = 0; w < 2; w++) begin
        b = {m[2 * w][15:4], 20'h0};
        l = {m[2 * w + 1][15:4], 20'hfffff};
        host(1'b1, b);
        host(1'b1, b - 32'h1);
        host(1'b1, l);
        host(1'b1, l + 32'h1);
      end
      seed = lfsr(seed);
      host(seed[0], seed);
      h_go <= 1'b0;
      @(posedge mclk_i);
    end
    repeat (3) @(posedge mclk_i);
    d = {26'h0, (m[2][15:4] <= m[3][15:4]), (m[0][15:4] <= m[1][15:4]), 4'h0};
    rd_own(bmwd_pkg::STATUS_IDX << 2, d);
    rd_own(bmwd_pkg::NP_COUNT_IDX << 2, {16'h0, n_np[15:0]});
    rd_own(bmwd_pkg::PF_COUNT_IDX << 2, {16'h0, n_pf[15:0]});
    rd_own(bmwd_pkg::MISS_COUNT_IDX << 2, {16'h0, n_miss[15:0]});
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    m = '{16'hfff0, 16'h0000, 16'hfff0, 16'h0000};
    for (int i = 0; i < 4; i++) rd_reg(i);
    rd_own(bmwd_pkg::MISS_COUNT_IDX << 2, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
